/* rtl/adc_fmt_if.sv */
// Carrier between the control top and the result aligner.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface adc_fmt_if;
    logic [9:0] result;
    logic       left_adjust;
    logic [7:0] low_byte;
    logic [7:0] high_byte;
    modport ctrl  (output result, output left_adjust, input low_byte, input high_byte);
    modport align (input result, input left_adjust, output low_byte, output high_byte);
endinterface
`default_nettype wire

/* rtl/adc_fmt_pkg.sv */
// Constants shared by the result formatter and its register front end.
// Assumes one 125 MHz clock and a synchronous active-high reset.
package adc_fmt_pkg;

    // ****************************************
    // Register byte offsets (Avalon word aligned)
    // ****************************************
    localparam logic [3:0] OFS_INPUT_MUX_SELECT = 4'h0;
    localparam logic [3:0] OFS_RESULT_LOW_BYTE  = 4'h4;
    localparam logic [3:0] OFS_RESULT_HIGH_BYTE = 4'h8;
    localparam logic [3:0] OFS_STATUS           = 4'hc;
    localparam logic [3:0] OFS_IRQ_MASK         = 4'h0;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int REFSEL_HI    = 7;
    localparam int REFSEL_LO    = 6;
    localparam int LEFT_ADJ_BIT = 5;
    localparam int CHSEL_HI     = 4;
    localparam int CHSEL_LO     = 0;
    localparam int ST_DONE_BIT  = 0;
    localparam int ST_BUSY_BIT  = 1;

    // ****************************************
    // Reset values and codes
    // ****************************************
    localparam logic [7:0] MUX_SELECT_RST = 8'h00;
    localparam logic [9:0] CODE_SE_MIN    = 10'h000;
    localparam logic [9:0] CODE_SE_MAX    = 10'h3ff;
    localparam logic [9:0] CODE_DIFF_MIN  = 10'h200;
    localparam logic [9:0] CODE_DIFF_MAX  = 10'h1ff;
    localparam int         RESULT_BITS    = 10;

    typedef enum logic [1:0] {
        REF_EXT_PIN   = 2'b00,
        REF_SUPPLY    = 2'b01,
        REF_INT_1V1   = 2'b10,
        REF_INT_2V56  = 2'b11
    } ref_sel_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } conv_state_e;

endpackage

/* rtl/adc_result_align.sv */
// Places a stored 10-bit result into the two result bytes.
// Assumes the stored result and alignment bit come from flip-flops.
`timescale 1ns/100ps
`default_nettype none
module adc_result_align (
    adc_fmt_if.align bus
);
    import adc_fmt_pkg::*;

    // ****************************************
    // Alignment
    // ****************************************
    always_comb begin
        if (bus.left_adjust) begin
            bus.high_byte = bus.result[9:2];
            bus.low_byte  = {bus.result[1:0], 6'h00};
        end else begin
            bus.high_byte = {6'h00, bus.result[9:8]};
            bus.low_byte  = bus.result[7:0];
        end
    end
endmodule
`default_nettype wire

/* rtl/adc_result_format.sv */
// Result formatting and reference select for a 10-bit converter.
// Assumes an analog core that takes start, channel and reference and
// returns a raw signed/unsigned code with a one-cycle done pulse.
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module adc_result_format (
    input  wire logic                    MCLK,
    input  wire logic                    RST,
    input  wire logic [3:0]              AVS_ADDRESS,
    input  wire logic                    AVS_READ,
    input  wire logic                    AVS_WRITE,
    input  wire logic [31:0]             AVS_WRITEDATA,
    input  wire logic [3:0]              AVS_BYTEENABLE,
    output logic [31:0]                  AVS_READDATA,
    output logic                         AVS_WAITREQUEST,
    input  wire logic                    CONV_START,
    input  wire logic                    CORE_DONE,
    input  wire logic [9:0]              CORE_CODE,
    output logic                         CORE_START,
    output adc_fmt_pkg::ref_sel_e        CORE_REF_SEL,
    output logic [4:0]                   CORE_CHANNEL_GAIN,
    output logic                         CORE_DIFFERENTIAL,
    output logic                         CONV_BUSY,
    output logic                         IRQ
);
    import adc_fmt_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        conv_state_e state;
        logic [7:0]  mux_sel;
        ref_sel_e    ref_act;
        logic [4:0]  chan_act;
        logic [9:0]  result;
        logic        done_flag;
        logic        irq_mask;
        logic        start;
        logic        ack;
        logic [31:0] rdata;
    } state_s;

    state_s s_reg;
    state_s s_next;
    adc_fmt_if fmt ();

    adc_result_align u_align (
        .bus (fmt.align)
    );

    // Differential combinations are codes 8 to 29
    function automatic logic is_diff(input logic [4:0] ch);
        is_diff = (ch >= 5'h08) && (ch <= 5'h1d);
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic rd_req;
        logic wr_req;
        logic done_set;
        // Read data fetched in the wait cycle, write lands when waitrequest is low
        rd_req   = AVS_READ && !s_reg.ack;
        wr_req   = AVS_WRITE && s_reg.ack;
        done_set = 1'b0;
        s_next       = s_reg;
        s_next.start = 1'b0;
        s_next.ack   = (AVS_READ || AVS_WRITE) && !s_reg.ack;

        case (s_reg.state)
            ST_IDLE: begin
                if (CONV_START) begin
                    s_next.ref_act  = ref_sel_e'(s_reg.mux_sel[REFSEL_HI:REFSEL_LO]);
                    s_next.chan_act = s_reg.mux_sel[CHSEL_HI:CHSEL_LO];
                    s_next.start    = 1'b1;
                    s_next.state    = ST_CONV;
                end
            end
            ST_CONV: begin
                if (CORE_DONE) begin
                    s_next.result = CORE_CODE;
                    done_set      = 1'b1;
                    s_next.state  = ST_IDLE;
                end
            end
            default: s_next.state = ST_IDLE;
        endcase

        s_next.rdata = 32'h0000_0000;
        if (rd_req) begin
            if (AVS_ADDRESS == OFS_INPUT_MUX_SELECT) begin
                s_next.rdata = {24'h000000, s_reg.mux_sel};
            end else if (AVS_ADDRESS == OFS_RESULT_LOW_BYTE) begin
                s_next.rdata = {24'h000000, fmt.low_byte};
            end else if (AVS_ADDRESS == OFS_RESULT_HIGH_BYTE) begin
                s_next.rdata = {24'h000000, fmt.high_byte};
            end else if (AVS_ADDRESS == OFS_STATUS) begin
                s_next.rdata = {23'h000000, s_reg.irq_mask, 6'h00,
                                (s_reg.state == ST_CONV), s_reg.done_flag};
            end
        end

        if (wr_req && AVS_BYTEENABLE[0]) begin
            if (AVS_ADDRESS == OFS_INPUT_MUX_SELECT) begin
                s_next.mux_sel = AVS_WRITEDATA[7:0];
            end else if (AVS_ADDRESS == OFS_STATUS) begin
                if (AVS_WRITEDATA[ST_DONE_BIT]) begin
                    s_next.done_flag = 1'b0;
                end
            end
        end
        if (wr_req && AVS_BYTEENABLE[1] && AVS_ADDRESS == OFS_STATUS) begin
            s_next.irq_mask = AVS_WRITEDATA[8];
        end
        if (done_set) begin
            s_next.done_flag = 1'b1;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge MCLK) begin
        if (RST) begin
            s_reg <= '{state: ST_IDLE, mux_sel: MUX_SELECT_RST, ref_act: REF_EXT_PIN,
                       chan_act: 5'h00, result: CODE_SE_MIN, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // alignment follows live bit
    assign fmt.left_adjust    = s_reg.mux_sel[LEFT_ADJ_BIT];
    assign fmt.result         = s_reg.result;
    assign AVS_WAITREQUEST    = (AVS_READ || AVS_WRITE) && !s_reg.ack;
    assign AVS_READDATA       = s_reg.rdata;
    assign CORE_REF_SEL       = s_reg.ref_act;
    assign CORE_CHANNEL_GAIN  = s_reg.chan_act;
    assign CORE_DIFFERENTIAL  = is_diff(s_reg.chan_act);
    assign CORE_START         = s_reg.start;
    assign CONV_BUSY          = (s_reg.state == ST_CONV);
    assign IRQ                = s_reg.done_flag && s_reg.irq_mask;

endmodule
`default_nettype wire

/* sim/adc_core_model.sv */
// Behavioural analog core: done pulse after a set delay.
// Assumes start is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
module adc_core_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [9:0] code,
    input  wire logic [3:0] dly,
    output logic            done = 1'b0,
    output logic [9:0]      code_out = 10'h155
);
    int cnt = 0;
    always @(posedge clk) begin
        done <= 1'b0;
        // Code invalid outside the done cycle
        code_out <= ~code_out;
        if (rst) cnt <= 0;
        else if (start) cnt <= dly;
        else if (cnt == 1) begin
            done <= 1'b1;
            code_out <= code;
            cnt <= 0;
        end
        else if (cnt > 1) cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

/* sim/adc_fmt_checker.sv */
// Port checker for the result formatter.
// Assumes a bind from the testbench top.
`timescale 1ns/100ps
`default_nettype none
module adc_fmt_checker (
    input wire logic                  MCLK,
    input wire logic                  RST,
    input wire logic                  AVS_READ,
    input wire logic                  AVS_WRITE,
    input wire logic                  AVS_WAITREQUEST,
    input wire logic                  CONV_START,
    input wire logic                  CORE_DONE,
    input wire logic                  CORE_START,
    input wire adc_fmt_pkg::ref_sel_e CORE_REF_SEL,
    input wire logic [4:0]            CORE_CHANNEL_GAIN,
    input wire logic                  CORE_DIFFERENTIAL,
    input wire logic                  CONV_BUSY,
    input wire logic                  IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    chk_start_taken: assert property (CONV_START && !CONV_BUSY |=> CORE_START && CONV_BUSY)
        else $error("start not taken");
    chk_start_pulse: assert property (CORE_START |=> !CORE_START)
        else $error("start pulse too long");
    chk_ref_held: assert property (CONV_BUSY && !CORE_START |-> $stable(CORE_REF_SEL))
        else $error("reference moved mid conversion");
    chk_chan_held: assert property (CONV_BUSY && !CORE_START |-> $stable(CORE_CHANNEL_GAIN))
        else $error("channel moved mid conversion");
    chk_busy_ends: assert property (CORE_DONE && CONV_BUSY |=> !CONV_BUSY)
        else $error("busy after done");
    chk_irq_cause: assert property ($rose(IRQ) |-> $past(CORE_DONE) || $past(AVS_WRITE))
        else $error("irq without cause");
    chk_diff_map: assert property (1'b1 |-> CORE_DIFFERENTIAL == (CORE_CHANNEL_GAIN inside {[8:29]}))
        else $error("differential flag wrong");
    chk_wait_state: assert property ((AVS_READ || AVS_WRITE) && !$past(AVS_READ || AVS_WRITE)
        |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("wait state wrong");
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the result formatter.
// Assumes the core model and checker files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import adc_fmt_pkg::*;
    logic MCLK = 0, rst = 1, rd = 0, wr = 0, cstart = 0, wreq, cdone, cst, diff, busy, irq;
    logic [3:0] adr = 0, dly = 1;
    logic [31:0] wdat = 0, rdat, s = 32'h448a;
    logic [9:0] code = 0, ccode;
    logic [9:0] last = CODE_SE_MIN;
    logic [4:0] chan;
    ref_sel_e refs;
    int err_total = 0, checked = 0, cyc = 0;
    logic [9:0] lim [4] = '{CODE_SE_MIN, CODE_SE_MAX, CODE_DIFF_MIN, CODE_DIFF_MAX};
    always #4 MCLK = ~MCLK;
    adc_result_format i_dut (.MCLK(MCLK), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .CONV_START(cstart), .CORE_DONE(cdone), .CORE_CODE(ccode),
        .CORE_START(cst), .CORE_REF_SEL(refs), .CORE_CHANNEL_GAIN(chan),
        .CORE_DIFFERENTIAL(diff), .CONV_BUSY(busy), .IRQ(irq));
    adc_core_model i_core (.clk(MCLK), .rst(rst), .start(cst), .code(code), .dly(dly),
        .done(cdone), .code_out(ccode));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [31:0] exp_b(input logic [9:0] r, input logic la, input logic hi);
        logic [15:0] w;
        w = la ? {r, 6'h00} : {6'h00, r};
        return hi ? {24'h0, w[15:8]} : {24'h0, w[7:0]};
    endfunction
    task automatic end_of_test;
        $display("errors %0d, comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge MCLK);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        do @(posedge MCLK); while (wreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp(rdat, e);
    endtask
    task automatic conv(input logic [7:0] m0, m1, input logic [9:0] c, input logic msk);
        bus(1'b1, OFS_STATUS, {23'h0, msk, 8'h00});
        bus(1'b1, OFS_INPUT_MUX_SELECT, {24'h0, m0});
        code <= c;
        cstart <= 1'b1;
        @(posedge MCLK) cstart <= 1'b0;
        bus(1'b1, OFS_INPUT_MUX_SELECT, {24'h0, m1});
        // Long conversion still running: old result, new layout
        if (dly == 4'd6) rd_chk(OFS_RESULT_HIGH_BYTE, exp_b(last, m1[5], 1'b1));
        while (busy !== 1'b0) @(posedge MCLK);
        @(posedge MCLK);
        cmp(refs, m0[7:6]);
        cmp(chan, m0[4:0]);
        cmp(diff, m0[4:0] inside {[8:29]});
        cmp(irq, msk);
        rd_chk(OFS_STATUS, {23'h0, msk, 8'h01});
        rd_chk(OFS_INPUT_MUX_SELECT, {24'h0, m1});
        rd_chk(OFS_RESULT_LOW_BYTE, exp_b(c, m1[5], 1'b0));
        rd_chk(OFS_RESULT_HIGH_BYTE, exp_b(c, m1[5], 1'b1));
        bus(1'b1, OFS_INPUT_MUX_SELECT, {24'h0, m1 ^ 8'h20});
        rd_chk(OFS_RESULT_HIGH_BYTE, exp_b(c, !m1[5], 1'b1));
        rd_chk(OFS_RESULT_LOW_BYTE, exp_b(c, !m1[5], 1'b0));
        bus(1'b1, OFS_STATUS, {23'h0, msk, 8'h01});
        @(posedge MCLK);
        cmp(irq, 1'b0);
        last = c;
    endtask
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        logic [7:0] m0;
        repeat (8) @(posedge MCLK);
        rst <= 1'b0;
        for (int a = 0; a < 16; a += 2) rd_chk(a[3:0], 32'h0);
        for (int i = 0; i < 8; i++) begin
            s = lfsr(s);
            // no voltage on external reference pin, any choice allowed
            m0 = {i[1:0], i[2], s[4:0]};
            // Gain channels only with the top internal reference
            if (m0[4:3] == 2'b01) m0[7:6] = 2'b11;
            dly <= i[0] ? 4'd1 : 4'd6;
            conv(m0, s[15:8], (i < 4) ? lim[i] : s[25:16], i[1]);
        end
        end_of_test();
    end
endmodule
bind adc_result_format adc_fmt_checker u_chk (.MCLK(MCLK), .RST(RST), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .CONV_START(CONV_START),
    .CORE_DONE(CORE_DONE), .CORE_START(CORE_START), .CORE_REF_SEL(CORE_REF_SEL),
    .CORE_CHANNEL_GAIN(CORE_CHANNEL_GAIN), .CORE_DIFFERENTIAL(CORE_DIFFERENTIAL),
    .CONV_BUSY(CONV_BUSY), .IRQ(IRQ));
`default_nettype wire
